/* File: logic/qdsic_top.v */
// Summary of operation
// - Keep a 16-bit serial input word.
// - Mode bits pick simultaneous or single update.
// - Outputs read zero until first valid frame.
// - Power-down mode with four termination choices.
// - Shift one bit per serial clock fall.
// - Shift only while frame sync is low.
// - Decode and apply on sixteenth falling edge.
// - Early frame sync rise discards the frame.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "qdsic_regs.vh"

module qdsic_top (
    input wire clock, // System clock, 125 MHz.
    input wire resetn, // Asynchronous reset, active low.
    input wire sclk, // Serial clock pin.
    input wire sync_n, // Frame sync pin, active low.
    input wire din, // Serial data pin.
    input wire psel, // APB select.
    input wire penable, // APB enable.
    input wire pwrite, // APB direction.
    input wire [11:0] paddr, // APB byte address.
    input wire [31:0] pwdata, // APB write data.
    output reg [31:0] prdata, // APB read data.
    output reg pready, // APB ready.
    output reg pslverr, // APB error on unmapped address.
    output wire [7:0] channel_a_output, // Channel A code.
    output wire [7:0] channel_b_output, // Channel B code.
    output wire [7:0] channel_c_output, // Channel C code.
    output wire [7:0] channel_d_output, // Channel D code.
    output reg powered_down, // All channels powered down.
    output reg [1:0] pd_term // Power-down termination choice.
);

// ****************************************************************
// Pin synchronisation and edge detection
// ****************************************************************
wire [2:0] pins_s;
wire sclk_s;
wire sync_s;
wire din_s;
reg sclk_prev_r;
reg sync_prev_r;

qdsic_sync u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in({din, sync_n, sclk}),
    .pin_out(pins_s)
);

assign sclk_s = pins_s[0];
assign sync_s = pins_s[1];
assign din_s = pins_s[2];

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        sclk_prev_r <= 1'b1;
        sync_prev_r <= 1'b1;
    end
    else
    begin
        sclk_prev_r <= sclk_s;
        sync_prev_r <= sync_s;
    end
end

// ****************************************************************
// Frame engine
// ****************************************************************
reg ctrl_en_r;
reg [`QDS_WORD_W-1:0] shift_r;
reg [4:0] bitcnt_r;
reg [`QDS_WORD_W-1:0] word_r;
reg [7:0] hold_r [0:3];
reg [7:0] out_r [0:3];
reg valid_seen_r;
reg [7:0] frames_r;
reg [7:0] aborts_r;
reg clr_req;

wire sclk_fall = sclk_prev_r & ~sclk_s;
wire sync_rise = ~sync_prev_r & sync_s;
wire shift_en = ~sync_s & sclk_fall & ctrl_en_r &
                (bitcnt_r < `QDS_CNT_FULL);
wire [`QDS_WORD_W-1:0] word_nxt = {shift_r[`QDS_WORD_W-2:0], din_s};
wire done = shift_en & (bitcnt_r == `QDS_CNT_LAST);
wire [1:0] w_addr = word_nxt[`QDS_ADDR_HI:`QDS_ADDR_LO];
wire [1:0] w_mode = word_nxt[`QDS_MODE_HI:`QDS_MODE_LO];
wire [7:0] w_code = word_nxt[`QDS_CODE_HI:`QDS_CODE_LO];

integer i;

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        shift_r <= 16'h0000;
        bitcnt_r <= 5'h00;
        word_r <= 16'h0000;
        valid_seen_r <= 1'b0;
        powered_down <= 1'b0;
        pd_term <= 2'h0;
        frames_r <= 8'h00;
        aborts_r <= 8'h00;
        for (i = 0; i < 4; i = i + 1)
        begin
            hold_r[i] <= `QDS_CODE_RST;
            out_r[i] <= `QDS_CODE_RST;
        end
    end
    else
    begin
        if (sync_s)
        begin
            // A partial frame is dropped and counted in aborts_r; nothing was applied.
            bitcnt_r <= 5'h00;
            if (sync_rise && bitcnt_r != 5'h00 &&
                bitcnt_r < `QDS_CNT_FULL)
                aborts_r <= aborts_r + 8'h01;
        end
        else if (shift_en)
        begin
            shift_r <= word_nxt;
            bitcnt_r <= bitcnt_r + 5'h01;
        end
        if (done)
        begin
            word_r <= word_nxt;
            valid_seen_r <= 1'b1;
            frames_r <= frames_r + 8'h01;
            case (w_mode)
            `QDS_MODE_HOLD:
                hold_r[w_addr] <= w_code;
            `QDS_MODE_ONE:
            begin
                hold_r[w_addr] <= w_code;
                out_r[w_addr] <= w_code;
                powered_down <= 1'b0;
            end
            `QDS_MODE_ALL:
            begin
                // All channels change together; the addressed one takes the new code, the rest their held codes.
                for (i = 0; i < 4; i = i + 1)
                    out_r[i] <= (i == w_addr) ? w_code : hold_r[i];
                hold_r[w_addr] <= w_code;
                powered_down <= 1'b0;
            end
            `QDS_MODE_PD:
            begin
                powered_down <= 1'b1;
                pd_term <= w_addr;
            end
            default:
                hold_r[w_addr] <= w_code;
            endcase
        end
        if (clr_req)
        begin
            frames_r <= 8'h00;
            aborts_r <= 8'h00;
        end
    end
end

assign channel_a_output = out_r[0];
assign channel_b_output = out_r[1];
assign channel_c_output = out_r[2];
assign channel_d_output = out_r[3];

// ****************************************************************
// APB slave
// ****************************************************************
wire setup = psel & ~penable;
wire access = psel & penable & pready;
reg [31:0] rdata_nxt;
reg err_nxt;

always @*
begin
    rdata_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
    `QDS_ADDR_CTRL:
        rdata_nxt = {31'h00000000, ctrl_en_r};
    `QDS_ADDR_STATUS:
        rdata_nxt = {27'h0000000, ~sync_s, pd_term, powered_down,
                     valid_seen_r};
    `QDS_ADDR_COUNT:
        rdata_nxt = {16'h0000, aborts_r, frames_r};
    `QDS_ADDR_WORD:
        rdata_nxt = {16'h0000, word_r};
    `QDS_ADDR_CHAN:
        rdata_nxt = {out_r[3], out_r[2], out_r[1], out_r[0]};
    default:
        err_nxt = 1'b1;
    endcase
end

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        ctrl_en_r <= `QDS_CTRL_RST;
        clr_req <= 1'b0;
    end
    else
    begin
        pready <= setup;
        clr_req <= 1'b0;
        // The error flag stands only in the access cycle, beside pready.
        pslverr <= setup & err_nxt;
        if (setup)
        begin
            prdata <= pwrite ? 32'h00000000 : rdata_nxt;
        end
        if (access && pwrite && paddr == `QDS_ADDR_CTRL)
        begin
            ctrl_en_r <= pwdata[`QDS_CTRL_EN_BIT];
            clr_req <= pwdata[`QDS_CTRL_CLR_BIT];
        end
    end
end

endmodule // qdsic_top

/* File: pkg/qdsic_regs.vh */
`ifndef QDSIC_REGS_VH
`define QDSIC_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define QDS_ADDR_CTRL 12'h000
`define QDS_ADDR_STATUS 12'h004
`define QDS_ADDR_COUNT 12'h008
`define QDS_ADDR_WORD 12'h00C
`define QDS_ADDR_CHAN 12'h010

`define QDS_CTRL_EN_BIT 0
`define QDS_CTRL_CLR_BIT 1
`define QDS_CTRL_RST 1'h1

// ****************************************************************
// Received word layout
// ****************************************************************
`define QDS_WORD_W 16
`define QDS_ADDR_HI 15
`define QDS_ADDR_LO 14
`define QDS_MODE_HI 13
`define QDS_MODE_LO 12
`define QDS_CODE_HI 11
`define QDS_CODE_LO 4

`define QDS_MODE_HOLD 2'h0
`define QDS_MODE_ONE 2'h1
`define QDS_MODE_ALL 2'h2
`define QDS_MODE_PD 2'h3

`define QDS_CNT_LAST 5'h0F
`define QDS_CNT_FULL 5'h10

// ****************************************************************
// Reset values
// ****************************************************************
`define QDS_SYNC_RST 3'h3
`define QDS_CODE_RST 8'h00

`endif

/* File: logic/qdsic_sync.v */
`timescale 1ns/1ps
`include "qdsic_regs.vh"

module qdsic_sync (
    input wire clock, // System clock.
    input wire resetn, // Asynchronous reset, active low.
    input wire [2:0] pin_in, // Raw pins {data, frame_n, sclk}.
    output reg [2:0] pin_out // Synchronised pins.
);

reg [2:0] meta_r;

// The first stage feeds only the second stage.
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        meta_r <= `QDS_SYNC_RST;
        pin_out <= `QDS_SYNC_RST;
    end
    else
    begin
        meta_r <= pin_in;
        pin_out <= meta_r;
    end
end

endmodule // qdsic_sync

/* File: verification/qdsic_properties.sv */
`timescale 1ns/1ps
module qdsic_props (
    input wire clock, // Clock.
    input wire resetn, // Reset.
    input wire sclk, // Link clock.
    input wire sync_n, // Frame sync.
    input wire psel, // Select.
    input wire penable, // Enable.
    input wire pready, // Ready.
    input wire pslverr, // Error.
    input wire [7:0] channel_a_output, // A.
    input wire [7:0] channel_b_output, // B.
    input wire [7:0] channel_c_output, // C.
    input wire [7:0] channel_d_output, // D.
    input wire powered_down // Down.
);
    // Counting raw pin falls keeps this count free of the design's own.
    reg sclk_r;
    reg [4:0] n_r;
    wire [32:0] outs = {powered_down, channel_d_output,
        channel_c_output, channel_b_output, channel_a_output};
    always @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            sclk_r <= 1'b1;
            n_r <= 5'h00;
        end
        else
        begin
            sclk_r <= sclk;
            n_r <= sync_n ? 5'h00 : n_r + {4'h0, sclk_r & ~sclk};
        end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready too long");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_zero_reset: assert property ($rose(resetn) |-> (outs == 33'h0)[*3])
        else $error("outputs not zero after reset");
    a_idle_stable: assert property (sync_n[*8] |=> $stable(outs))
        else $error("outputs moved while idle");
    a_abort_keeps: assert property ($rose(sync_n) && n_r < 5'h10
        |=> $stable(outs)[*6]) else $error("abort changed outputs");
    a_update_sixteen: assert property ($changed(outs) |-> n_r == 5'h10)
        else $error("update without full word");
endmodule // qdsic_props
bind qdsic_top qdsic_props u_qdsic_props (.clock, .resetn, .sclk, .sync_n,
    .psel, .penable, .pready, .pslverr, .channel_a_output, .channel_b_output,
    .channel_c_output, .channel_d_output, .powered_down);

/* File: verification/qdsic_host.sv */
`timescale 1ns/1ps
module qdsic_host (
    output reg sclk, // Link clock.
    output reg sync_n, // Frame sync.
    output reg din // Serial data.
);
    initial
    begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end
    // A 160 ns period stays far below the top link rate.
    task send(input [15:0] w, input integer n, input hold);
        integer i;
        begin
            #3 sync_n = hold;
            for (i = 0; i < n; i = i + 1)
            begin
                din = w[15 - i];
                #80 sclk = 1'b0;
                #80 sclk = 1'b1;
            end
            #80 sync_n = 1'b1;
            // A released line must not repeat the last bit.
            din = ~din;
        end
    endtask
endmodule // qdsic_host

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`include "qdsic_regs.vh"
module tb_top;
    reg clock = 1'b0;
    reg resetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [31:0] rd;
    reg err;
    integer err_count = 0;
    integer tests_run = 0;
    wire sclk, sync_n, din, pready, pslverr, powered_down;
    wire [31:0] prdata;
    wire [7:0] ch_a, ch_b, ch_c, ch_d;
    wire [1:0] pd_term;
    wire [31:0] outs = {ch_d, ch_c, ch_b, ch_a};
    always #4 clock = ~clock;
    qdsic_host u_qdsic_host (.sclk(sclk), .sync_n(sync_n), .din(din));
    qdsic_top u_qdsic_top (.clock, .resetn, .sclk, .sync_n, .din, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .channel_a_output(ch_a), .channel_b_output(ch_b),
        .channel_c_output(ch_c), .channel_d_output(ch_d),
        .powered_down, .pd_term);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("unexpected at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clock);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            @(posedge clock);
            while (pready !== 1'b1)
                @(posedge clock);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task fr(input [15:0] w, input integer n, input hold);
        begin
            u_qdsic_host.send(w, n, hold);
            repeat (4) @(posedge clock);
        end
    endtask
    task conclude;
        begin
            if (err_count == 0 && tests_run > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        err_count = err_count + 1;
        conclude;
    end
    initial
    begin
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        apb(1'b0, `QDS_ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `QDS_ADDR_CHAN, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h0);
        chk({31'h00000000, err}, 32'h00000001);
        fr(16'h1A50, 10, 1'b0);
        chk(outs, 32'h0);
        apb(1'b0, `QDS_ADDR_COUNT, 32'h0);
        chk(rd, 32'h100);
        fr(16'h55AF, 16, 1'b0);
        chk(outs, 32'h5A00);
        apb(1'b0, `QDS_ADDR_CHAN, 32'h0);
        chk(rd, 32'h5A00);
        fr(16'h8330, 16, 1'b0);
        chk(outs, 32'h5A00);
        fr(16'hE440, 16, 1'b0);
        chk(outs, 32'h44335A00);
        fr(16'hB000, 16, 1'b0);
        chk({pd_term, powered_down}, 32'h5);
        apb(1'b0, `QDS_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000000B);
        fr(16'h1770, 16, 1'b0);
        chk({outs[30:0], powered_down}, 32'h8866B4EE);
        apb(1'b0, `QDS_ADDR_WORD, 32'h0);
        chk(rd, 32'h00001770);
        fr(16'h5FF0, 16, 1'b1);
        chk(outs, 32'h44335A77);
        apb(1'b1, `QDS_ADDR_CTRL, 32'h0);
        fr(16'h5FF0, 16, 1'b0);
        chk(outs, 32'h44335A77);
        apb(1'b0, `QDS_ADDR_COUNT, 32'h0);
        chk(rd, 32'h00000105);
        apb(1'b1, `QDS_ADDR_CTRL, 32'h3);
        apb(1'b0, `QDS_ADDR_COUNT, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, `QDS_ADDR_CTRL, 32'h0);
        chk(rd, 32'h00000001);
        // A second reset must bring every output back to zero.
        @(posedge clock);
        resetn <= 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        chk({outs[30:0], powered_down}, 32'h00000000);
        apb(1'b0, `QDS_ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000000);
        conclude;
    end
endmodule // tb_top
